// ==== logic/op_timing_map.vh ====
// Constants for the instruction execution timing unit
//
// Operation
// - Every read, prefetch and write bus cycle of an instruction falls inside its total clock count.
// - Each instruction form has a read/prefetch/write triple reported beside its clock total; the prefetch is one in the worst case only.
// - Unary operations and zero test on a data register take 0, 2 or 3 clocks, the worst case with one prefetch.
// - Memory forms of zero, invert, invert-with-extend and complement take 3, 4 or 6 clocks with one write.
// - Logical shifts of a data register take 1 clock static or 3 dynamic best case, three more from cache.
// - Shift and rotate time does not depend on the number of positions moved.
// - Rotate through extend on a data register, either direction, takes 9 clocks best and 12 otherwise.
// - Single-bit operations on a data register take 1, 4 or 5 clocks; memory modify forms add one write.
// - Field memory forms use one read when the field spans under five bytes and two when it spans five.
// - A 32-bit field uses two operand reads across five byte positions and one across four.
// - Memory unary, shift, rotate and register-numbered bit forms add the address fetch time.
// - Memory zero, conditional set and test-and-mark add the address calculation time instead.
// - Bit operations with an immediate bit number on memory add the immediate address fetch time.
// - Every field operation on memory adds the immediate address calculation time.
`ifndef OP_TIMING_MAP_VH
`define OP_TIMING_MAP_VH

// =====================================
// Operation codes
`define OP_ZERO_OPERAND      5'h00
`define OP_ARITH_INVERT      5'h01
`define OP_INVERT_EXTEND     5'h02
`define OP_COMPLEMENT        5'h03
`define OP_COMPARE_ZERO      5'h04
`define OP_TEST_MARK_BYTE    5'h05
`define OP_COND_SET          5'h06
`define OP_LOGIC_LEFT_SHIFT  5'h07
`define OP_LOGIC_RIGHT_SHIFT 5'h08
`define OP_ROTATE_EXTEND     5'h09
`define OP_BIT_TEST          5'h0a
`define OP_BIT_TOGGLE        5'h0b
`define OP_BIT_ZERO          5'h0c
`define OP_BIT_ONE           5'h0d
`define OP_FIELD_TEST        5'h0e
`define OP_FIELD_TOGGLE      5'h0f
`define OP_FIELD_ZERO        5'h10
`define OP_FIELD_ONE         5'h11

// =====================================
// Address time kinds
`define EA_NONE      3'h0
`define EA_FETCH     3'h1
`define EA_CALC      3'h2
`define EA_IMM_FETCH 3'h3
`define EA_IMM_CALC  3'h4

// =====================================
// Overlap cases
`define CASE_BEST  2'h0
`define CASE_CACHE 2'h1
`define CASE_WORST 2'h2

// =====================================
// Field span limit in bits (offset within byte plus width)
`define FIELD_FOUR_BYTE_BITS 6'h20

`endif

// ==== logic/op_timing_table.v ====
// Timing table lookup for unary, shift, rotate, bit and field operations
`timescale 1ns/1ps
`default_nettype none
`include "op_timing_map.vh"

module op_timing_table (
  input  wire [4:0] op,
  input  wire       mem_form,
  input  wire       dyn_count,
  input  wire       imm_bitnum,
  input  wire       span5,
  input  wire [1:0] sel_case,
  output reg  [7:0] clocks,
  output reg  [1:0] reads,
  output reg  [1:0] pfetch,
  output reg  [1:0] writes,
  output reg  [2:0] ea_kind
);

  reg [7:0] best;
  reg [7:0] cache;
  reg [7:0] worst;

  always @* begin
    best    = 8'h00;
    cache   = 8'h02;
    worst   = 8'h03;
    reads   = 2'h0;
    writes  = 2'h0;
    ea_kind = `EA_NONE;
    case (op)
      `OP_ZERO_OPERAND, `OP_ARITH_INVERT, `OP_INVERT_EXTEND, `OP_COMPLEMENT: begin
        if (mem_form) begin
          best    = 8'h03;
          cache   = 8'h04;
          worst   = 8'h06;
          writes  = 2'h1;
          ea_kind = (op == `OP_ZERO_OPERAND) ? `EA_CALC : `EA_FETCH;
        end
      end
      `OP_COMPARE_ZERO: begin
        if (mem_form)
          ea_kind = `EA_FETCH;
      end
      `OP_TEST_MARK_BYTE: begin
        best  = mem_form ? 8'h0c : 8'h01;
        cache = mem_form ? 8'h0c : 8'h04;
        worst = mem_form ? 8'h0d : 8'h04;
        if (mem_form) begin
          reads   = 2'h1;
          writes  = 2'h1;
          ea_kind = `EA_CALC;
        end
      end
      `OP_COND_SET: begin
        best  = mem_form ? 8'h06 : 8'h01;
        cache = mem_form ? 8'h06 : 8'h04;
        worst = mem_form ? 8'h06 : 8'h04;
        if (mem_form) begin
          writes  = 2'h1;
          ea_kind = `EA_CALC;
        end
      end
      // Shift distance never enters here
      `OP_LOGIC_LEFT_SHIFT, `OP_LOGIC_RIGHT_SHIFT: begin
        if (mem_form) begin
          best    = 8'h05;
          cache   = 8'h05;
          worst   = 8'h06;
          writes  = 2'h1;
          ea_kind = `EA_FETCH;
        end else begin
          best  = dyn_count ? 8'h03 : 8'h01;
          cache = dyn_count ? 8'h06 : 8'h04;
          worst = cache;
        end
      end
      `OP_ROTATE_EXTEND: begin
        if (mem_form) begin
          best    = 8'h05;
          cache   = 8'h05;
          worst   = 8'h06;
          writes  = 2'h1;
          ea_kind = `EA_FETCH;
        end else begin
          best  = 8'h09;
          cache = 8'h0c;
          worst = 8'h0c;
        end
      end
      `OP_BIT_TEST, `OP_BIT_TOGGLE, `OP_BIT_ZERO, `OP_BIT_ONE: begin
        best  = mem_form ? 8'h04 : 8'h01;
        cache = 8'h04;
        worst = 8'h05;
        if (mem_form) begin
          writes  = (op == `OP_BIT_TEST) ? 2'h0 : 2'h1;
          ea_kind = imm_bitnum ? `EA_IMM_FETCH : `EA_FETCH;
        end
      end
      `OP_FIELD_TEST: begin
        if (mem_form) begin
          best    = span5 ? 8'h0f : 8'h0b;
          cache   = best;
          worst   = span5 ? 8'h10 : 8'h0c;
          reads   = span5 ? 2'h2 : 2'h1;
          ea_kind = `EA_IMM_CALC;
        end else begin
          best  = 8'h03;
          cache = 8'h06;
          worst = 8'h07;
        end
      end
      `OP_FIELD_TOGGLE, `OP_FIELD_ZERO, `OP_FIELD_ONE: begin
        if (mem_form) begin
          best    = span5 ? 8'h18 : 8'h10;
          cache   = best;
          worst   = best;
          reads   = span5 ? 2'h2 : 2'h1;
          writes  = reads;
          ea_kind = `EA_IMM_CALC;
        end else begin
          best  = 8'h09;
          cache = 8'h0c;
          worst = 8'h0c;
        end
      end
      default: begin
        best  = 8'h00;
        cache = 8'h02;
        worst = 8'h03;
      end
    endcase
    // Every worst-case figure here carries exactly one prefetch
    pfetch = (sel_case == `CASE_WORST) ? 2'h1 : 2'h0;
    case (sel_case)
      `CASE_BEST:  clocks = best;
      `CASE_CACHE: clocks = cache;
      default:     clocks = worst;
    endcase
  end

endmodule // op_timing_table

`default_nettype wire

// ==== logic/op_timing_unit.v ====
// Execution timing unit: looks up cycle figures and paces an instruction's bus cycles
`timescale 1ns/1ps
`default_nettype none
`include "op_timing_map.vh"

module op_timing_unit (
  input  wire       clk,
  input  wire       resetn,
  input  wire       start,
  input  wire [4:0] op,
  input  wire       mem_form,
  input  wire       dyn_count,
  input  wire [4:0] shift_count,
  input  wire       imm_bitnum,
  input  wire [2:0] field_offset,
  input  wire [4:0] field_width,
  input  wire       full_overlap,
  input  wire       cache_hit,
  input  wire [7:0] ea_fetch_time,
  input  wire [7:0] ea_calc_time,
  input  wire [7:0] imm_fetch_time,
  input  wire [7:0] imm_calc_time,
  output wire       busy,
  output reg        done,
  output reg  [8:0] total_clocks,
  output reg  [1:0] read_count,
  output reg  [1:0] prefetch_count,
  output reg  [1:0] write_count,
  output reg        span_five,
  output reg        read_strobe,
  output reg        prefetch_strobe,
  output reg        write_strobe
);

  // =====================================
  // Case selection and field span
  reg  [1:0] sel_case;
  wire [5:0] width_bits;
  wire [5:0] span_bits;
  wire       span5;

  always @* begin
    if (full_overlap)
      sel_case = `CASE_BEST;
    else if (cache_hit)
      sel_case = `CASE_CACHE;
    else
      sel_case = `CASE_WORST;
  end

  // Width code zero means a full 32-bit field
  assign width_bits = (field_width == 5'h00) ? 6'h20 : {1'b0, field_width};
  assign span_bits  = {3'h0, field_offset} + width_bits;
  assign span5      = (span_bits > `FIELD_FOUR_BYTE_BITS);

  // =====================================
  // Table lookup
  wire [7:0] tab_clocks;
  wire [1:0] tab_reads;
  wire [1:0] tab_pfetch;
  wire [1:0] tab_writes;
  wire [2:0] tab_ea;
  reg  [7:0] ea_add;

  op_timing_table u_table (
    .op         (op),
    .mem_form   (mem_form),
    .dyn_count  (dyn_count),
    .imm_bitnum (imm_bitnum),
    .span5      (span5),
    .sel_case   (sel_case),
    .clocks     (tab_clocks),
    .reads      (tab_reads),
    .pfetch     (tab_pfetch),
    .writes     (tab_writes),
    .ea_kind    (tab_ea)
  );

  always @* begin
    case (tab_ea)
      `EA_FETCH:     ea_add = ea_fetch_time;
      `EA_CALC:      ea_add = ea_calc_time;
      `EA_IMM_FETCH: ea_add = imm_fetch_time;
      `EA_IMM_CALC:  ea_add = imm_calc_time;
      default:       ea_add = 8'h00;
    endcase
  end

  // =====================================
  // Sequencer
  // Bus cycles are issued inside the counted window, never after it;
  // reads first, then writes, prefetch last so it overlaps the next fetch.
  // One-hot states: a single bit per state keeps the decode shallow
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RUN  = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [8:0] remain_q;
  reg  [8:0] remain_d;
  reg  [1:0] rd_left_q;
  reg  [1:0] rd_left_d;
  reg  [1:0] pf_left_q;
  reg  [1:0] pf_left_d;
  reg  [1:0] wr_left_q;
  reg  [1:0] wr_left_d;
  reg        rd_fire_d;
  reg        pf_fire_d;
  reg        wr_fire_d;
  wire       take;
  wire [8:0] grand_total;

  // Only an idle sequencer accepts; a start in run or done is dropped
  assign take        = (state_q == ST_IDLE) && start;
  assign grand_total = {1'b0, tab_clocks} + {1'b0, ea_add};
  assign busy        = (state_q == ST_RUN);

  // A zero total skips run and answers with done one cycle later
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start)
          state_d = (grand_total == 9'h000) ? ST_DONE : ST_RUN;
      end
      ST_RUN: begin
        if (remain_q == 9'h001)
          state_d = ST_DONE;
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // =====================================
  // Bus cycle issue
  // At most one bus cycle per run clock; every table total covers its own
  // triple, so no cycle is ever pushed past the end of the window.
  // Prefetch goes last, where it overlaps the next instruction's fetch.
  always @* begin
    remain_d  = remain_q;
    rd_left_d = rd_left_q;
    pf_left_d = pf_left_q;
    wr_left_d = wr_left_q;
    rd_fire_d = 1'b0;
    pf_fire_d = 1'b0;
    wr_fire_d = 1'b0;
    if (take) begin
      remain_d  = grand_total;
      rd_left_d = tab_reads;
      pf_left_d = tab_pfetch;
      wr_left_d = tab_writes;
    end else if (busy) begin
      remain_d = remain_q - 9'h001;
      // Reads first: a write-back needs its operand in hand
      if (rd_left_q != 2'h0) begin
        rd_fire_d = 1'b1;
        rd_left_d = rd_left_q - 2'h1;
      end else if (wr_left_q != 2'h0) begin
        wr_fire_d = 1'b1;
        wr_left_d = wr_left_q - 2'h1;
      end else if (pf_left_q != 2'h0) begin
        pf_fire_d = 1'b1;
        pf_left_d = pf_left_q - 2'h1;
      end
    end
  end

  // =====================================
  // State and strobe registers
  // Strobes are registered so each stands one full cycle on the bus
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q         <= ST_IDLE;
      remain_q        <= 9'h000;
      rd_left_q       <= 2'h0;
      pf_left_q       <= 2'h0;
      wr_left_q       <= 2'h0;
      done            <= 1'b0;
      read_strobe     <= 1'b0;
      prefetch_strobe <= 1'b0;
      write_strobe    <= 1'b0;
    end else begin
      state_q         <= state_d;
      remain_q        <= remain_d;
      rd_left_q       <= rd_left_d;
      pf_left_q       <= pf_left_d;
      wr_left_q       <= wr_left_d;
      done            <= (state_d == ST_DONE);
      read_strobe     <= rd_fire_d;
      prefetch_strobe <= pf_fire_d;
      write_strobe    <= wr_fire_d;
    end
  end

  // =====================================
  // Result hold
  // Figures stand from one accepted start to the next, so a slow reader
  // may pick them up at any time while the sequencer is idle.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      total_clocks   <= 9'h000;
      read_count     <= 2'h0;
      prefetch_count <= 2'h0;
      write_count    <= 2'h0;
      span_five      <= 1'b0;
    end else if (take) begin
      // shift_count deliberately unused: time is independent of distance
      total_clocks   <= grand_total;
      read_count     <= tab_reads;
      prefetch_count <= tab_pfetch;
      write_count    <= tab_writes;
      span_five      <= span5;
    end
  end

endmodule // op_timing_unit

`default_nettype wire

// ==== verif/mem_model.sv ====
// External memory bus model: tallies operand and prefetch bus cycles
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// Bus cycle tally
module mem_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        read_strobe,
  input  wire logic        prefetch_strobe,
  input  wire logic        write_strobe,
  output var  logic [15:0] rd_seen,
  output var  logic [15:0] pf_seen,
  output var  logic [15:0] wr_seen
);
  // Zero wait states: the core's timing figures assume memory never stalls
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_seen <= 16'h0000;
      pf_seen <= 16'h0000;
      wr_seen <= 16'h0000;
    end else begin
      rd_seen <= rd_seen + {15'h0000, read_strobe};
      pf_seen <= pf_seen + {15'h0000, prefetch_strobe};
      wr_seen <= wr_seen + {15'h0000, write_strobe};
    end
  end
endmodule // mem_model
`default_nettype wire

// ==== verif/op_timing_checker.sv ====
// Assertion checker for the execution timing unit
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// Timing and bus-cycle checks
module op_timing_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       start,
  input wire logic       full_overlap,
  input wire logic       cache_hit,
  input wire logic       busy,
  input wire logic       done,
  input wire logic [8:0] total_clocks,
  input wire logic [1:0] read_count,
  input wire logic [1:0] prefetch_count,
  input wire logic [1:0] write_count,
  input wire logic       read_strobe,
  input wire logic       prefetch_strobe,
  input wire logic       write_strobe
);
  logic [8:0] bn_q;
  logic [1:0] rn_q;
  logic [1:0] pn_q;
  logic [1:0] wn_q;
  wire        take = start && !busy && !done;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Tallies restart at each accepted start, so a stale count cannot hide
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bn_q <= 9'h000;
      rn_q <= 2'h0;
      pn_q <= 2'h0;
      wn_q <= 2'h0;
    end else begin
      bn_q <= busy ? bn_q + 9'h001 : 9'h000;
      rn_q <= take ? 2'h0 : rn_q + {1'b0, read_strobe};
      pn_q <= take ? 2'h0 : pn_q + {1'b0, prefetch_strobe};
      wn_q <= take ? 2'h0 : wn_q + {1'b0, write_strobe};
    end
  end
  a_done_after_busy: assert property ($fell(busy) |-> done) else $error("done missing");
  a_busy_length: assert property (done |-> bn_q == total_clocks) else $error("busy length");
  a_done_single: assert property (done |=> !done) else $error("done too long");
  a_strobe_in_run: assert property ((read_strobe || prefetch_strobe || write_strobe) |-> $past(busy))
    else $error("strobe outside run");
  a_read_total: assert property (done |-> rn_q + {1'b0, read_strobe} == read_count) else $error("reads");
  a_prefetch_total: assert property (done |-> pn_q + {1'b0, prefetch_strobe} == prefetch_count)
    else $error("prefetches");
  a_write_total: assert property (done |-> wn_q + {1'b0, write_strobe} == write_count) else $error("writes");
  a_reads_first: assert property (write_strobe |-> rn_q == read_count) else $error("write before read");
  a_best_no_fetch: assert property (take && full_overlap |=> prefetch_count == 2'h0) else $error("best");
  a_worst_fetch: assert property (take && !full_overlap && !cache_hit |=> prefetch_count == 2'h1)
    else $error("worst");
  c_overlap: cover property (take && full_overlap);
  c_two_reads: cover property (done && read_count == 2'h2);
  c_zero_time: cover property (take ##1 done);
endmodule // op_timing_checker

bind op_timing_unit op_timing_checker chk (
  .clk(clk), .resetn(resetn), .start(start), .full_overlap(full_overlap), .cache_hit(cache_hit),
  .busy(busy), .done(done), .total_clocks(total_clocks), .read_count(read_count),
  .prefetch_count(prefetch_count), .write_count(write_count), .read_strobe(read_strobe),
  .prefetch_strobe(prefetch_strobe), .write_strobe(write_strobe)
);
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking testbench for the execution timing unit
`timescale 1ns/1ps
`default_nettype none
`include "op_timing_map.vh"
// ==============================================================
// Bench
module tb_top;
  localparam int fetch_t = 5;
  localparam int calc_t  = 7;
  localparam int ifetch_t = 11;
  localparam int icalc_t = 2;
  logic        clk, resetn, start, mem_form, dyn_count, imm_bitnum, full_overlap, cache_hit;
  logic [4:0]  op, shift_count, field_width;
  logic [2:0]  field_offset;
  logic [7:0]  ea_fetch_time, ea_calc_time, imm_fetch_time, imm_calc_time;
  wire         busy, done, span_five, read_strobe, prefetch_strobe, write_strobe;
  wire  [8:0]  total_clocks;
  wire  [1:0]  read_count, prefetch_count, write_count;
  wire  [15:0] rd_seen, pf_seen, wr_seen;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  op_timing_unit dut (
    .clk(clk), .resetn(resetn), .start(start), .op(op), .mem_form(mem_form), .dyn_count(dyn_count),
    .shift_count(shift_count), .imm_bitnum(imm_bitnum), .field_offset(field_offset),
    .field_width(field_width), .full_overlap(full_overlap), .cache_hit(cache_hit),
    .ea_fetch_time(ea_fetch_time), .ea_calc_time(ea_calc_time), .imm_fetch_time(imm_fetch_time),
    .imm_calc_time(imm_calc_time), .busy(busy), .done(done), .total_clocks(total_clocks),
    .read_count(read_count), .prefetch_count(prefetch_count), .write_count(write_count),
    .span_five(span_five), .read_strobe(read_strobe), .prefetch_strobe(prefetch_strobe),
    .write_strobe(write_strobe));
  mem_model mem (
    .clk(clk), .resetn(resetn), .read_strobe(read_strobe), .prefetch_strobe(prefetch_strobe),
    .write_strobe(write_strobe), .rd_seen(rd_seen), .pf_seen(pf_seen), .wr_seen(wr_seen));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Case c: 0 overlap (cache also set, overlap must win), 1 cache hit, 2 neither
  task automatic run(input logic [4:0] o, input logic m, dy, im, input logic [2:0] fo, input logic [4:0] fw,
                     input int c, et, er, ep, ew);
    int n;
    int b;
    logic [15:0] r0, p0, w0;
    @(negedge clk);
    {op, mem_form, dyn_count, imm_bitnum, field_offset, field_width} = {o, m, dy, im, fo, fw};
    full_overlap = (c == 0);
    cache_hit = (c != 2);
    r0 = rd_seen;
    p0 = pf_seen;
    w0 = wr_seen;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    b = 0;
    while (done !== 1'b1 && n < 200) begin
      b += (busy === 1'b1);
      @(negedge clk);
      n++;
    end
    chk(done, 16'h0001);
    chk(total_clocks, 16'(et));
    chk(16'(b), 16'(et));
    chk(read_count, 16'(er));
    chk(prefetch_count, 16'(ep));
    chk(write_count, 16'(ew));
    @(negedge clk);
    chk(rd_seen - r0, 16'(er));
    chk(pf_seen - p0, 16'(ep));
    chk(wr_seen - w0, 16'(ew));
  endtask

  task automatic t_unary();
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 5; i++)
        for (int c = 0; c < 3; c++)
          if (m == 1 && i < 4)
            run(i[4:0], 1'b1, 1'b0, 1'b0, 3'h0, 5'h00, c,
                (c == 0 ? 3 : c == 1 ? 4 : 6) + (i == 0 ? calc_t : fetch_t), 0, c / 2, 1);
          else
            run(i[4:0], m[0], 1'b0, 1'b0, 3'h0, 5'h00, c, (c == 0 ? 0 : c + 1) + m * fetch_t, 0, c / 2, 0);
    for (int c = 0; c < 3; c++)
      run(`OP_TEST_MARK_BYTE, 1'b1, 1'b0, 1'b0, 3'h0, 5'h00, c, (c == 2 ? 13 : 12) + calc_t, 1, c / 2, 1);
    $display("test unary done");
  endtask

  task automatic t_shift();
    for (int i = 7; i < 10; i++)
      for (int dy = 0; dy < 2; dy++)
        for (int k = 0; k < 2; k++)
          for (int c = 0; c < 3; c++)
            if (i < 9 || dy == 0) begin
              shift_count = k ? 5'h1f : 5'h01;
              run(i[4:0], 1'b0, dy[0], 1'b0, 3'h0, 5'h00, c,
                  i == 9 ? (c ? 12 : 9) : (dy ? 3 : 1) + (c ? 3 : 0), 0, c / 2, 0);
            end
    $display("test shift done");
  endtask

  task automatic t_bit();
    for (int i = 10; i < 14; i++)
      for (int m = 0; m < 2; m++)
        for (int im = 0; im < 2; im++)
          for (int c = 0; c < 3; c++)
            run(i[4:0], m[0], 1'b0, im[0], 3'h0, 5'h00, c,
                m ? (c == 2 ? 5 : 4) + (im ? ifetch_t : fetch_t) : (c == 0 ? 1 : c + 3),
                0, c / 2, (m == 1 && i != 10) ? 1 : 0);
    $display("test bit done");
  endtask

  task automatic t_field();
    for (int c = 0; c < 3; c++)
      run(`OP_FIELD_TEST, 1'b0, 1'b0, 1'b0, 3'h0, 5'h08, c, c == 0 ? 3 : c + 5, 0, c / 2, 0);
    for (int k = 0; k < 3; k++)
      for (int c = 0; c < 3; c++) begin
        run(`OP_FIELD_TEST, 1'b1, 1'b0, 1'b0, k == 2 ? 3'h1 : 3'h0, k == 0 ? 5'h08 : 5'h00, c,
            (k == 2 ? 15 : 11) + c / 2 + icalc_t, k == 2 ? 2 : 1, c / 2, 0);
        chk(span_five, 16'(k / 2));
      end
    run(`OP_FIELD_ONE, 1'b1, 1'b0, 1'b0, 3'h1, 5'h00, 2, 24 + icalc_t, 2, 1, 2);
    $display("test field done");
  endtask

  task automatic t_more();
    for (int c = 0; c < 3; c++) begin
      run(`OP_TEST_MARK_BYTE, 1'b0, 1'b0, 1'b0, 3'h0, 5'h00, c, c ? 4 : 1, 0, c / 2, 0);
      for (int m = 0; m < 2; m++)
        run(`OP_COND_SET, m[0], 1'b0, 1'b0, 3'h0, 5'h00, c, m ? 6 + calc_t : (c ? 4 : 1), 0, c / 2, m);
      for (int i = 7; i < 10; i++)
        run(i[4:0], 1'b1, 1'b0, 1'b0, 3'h0, 5'h00, c, (c == 2 ? 6 : 5) + fetch_t, 0, c / 2, 1);
      for (int i = 15; i < 18; i++)
        for (int k = 0; k < 3; k++)
          run(i[4:0], k != 0, 1'b0, 1'b0, k == 2 ? 3'h1 : 3'h0, 5'h00, c,
              k == 0 ? (c ? 12 : 9) : (k == 2 ? 24 : 16) + icalc_t, k, c / 2, k);
    end
    $display("test more done");
  endtask

  task automatic t_refuse();
    int n;
    @(negedge clk);
    {op, mem_form, dyn_count, full_overlap, cache_hit} = {`OP_ROTATE_EXTEND, 4'h3};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (3) @(negedge clk);
    {op, mem_form} = {`OP_FIELD_TEST, 1'b1};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(done, 16'h0001);
    // Start in the done cycle must be dropped as well
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk(busy, 16'h0000);
    chk(total_clocks, 16'h0009);
    // Reset in mid-run drops the instruction and clears every figure
    @(negedge clk);
    {op, mem_form, field_offset, field_width, full_overlap, cache_hit} = {`OP_FIELD_ONE, 1'b1, 3'h1, 5'h00, 2'h0};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (4) @(negedge clk);
    chk(busy, 16'h0001);
    resetn = 1'b0;
    @(negedge clk);
    chk(busy, 16'h0000);
    chk(total_clocks, 16'h0000);
    chk(read_count, 16'h0000);
    resetn = 1'b1;
    run(`OP_ROTATE_EXTEND, 1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 2, 12, 0, 1, 0);
    $display("test refuse done");
  endtask

  initial begin
    {resetn, start, mem_form, dyn_count, imm_bitnum, full_overlap, cache_hit} = 7'h00;
    {op, shift_count, field_width, field_offset} = 18'h00000;
    ea_fetch_time = 8'h05;
    ea_calc_time = 8'h07;
    imm_fetch_time = 8'h0b;
    imm_calc_time = 8'h02;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    t_unary();
    t_shift();
    t_bit();
    t_field();
    t_more();
    t_refuse();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
